// File: core/epw_pkg.sv
// Purpose: shared constants for the enhanced pwm and event trigger block
// Assumes: clk is the oscillator clock, four clocks form one instruction cycle
// Notes:   field positions index the 8-bit unit control byte; DB_CNT_HI indexes the dead band register
package epw_pkg;

  // timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TOSC_PER_INSN  = 4;
  localparam int unsigned INSN_CYCLES    = TOSC_PER_INSN * 1;

  // unit control byte fields, and the top bit of the dead band count
  localparam int unsigned CTL_CFG_HI     = 7;
  localparam int unsigned CTL_CFG_LO     = 6;
  localparam int unsigned CTL_DLSB_HI    = 5;
  localparam int unsigned CTL_DLSB_LO    = 4;
  localparam int unsigned CTL_MODE_HI    = 3;
  localparam int unsigned CTL_MODE_LO    = 0;
  localparam int unsigned DB_CNT_HI      = 6;

  // mode field codes
  localparam logic [3:0]  MODE_CMP_SWIRQ = 4'ha;
  localparam logic [3:0]  MODE_CMP_TRIG  = 4'hb;
  localparam logic [1:0]  MODE_CMP_GRP   = 2'h2;
  localparam logic [1:0]  MODE_PWM_GRP   = 2'h3;

  // output configuration codes
  localparam logic [1:0]  CFG_SINGLE     = 2'h0;
  localparam logic [1:0]  CFG_FULL_FWD   = 2'h1;
  localparam logic [1:0]  CFG_HALF       = 2'h2;
  localparam logic [1:0]  CFG_FULL_REV   = 2'h3;

  // prescale select: 0 -> 1, 1 -> 4, 2/3 -> 16
  localparam logic [1:0]  PRE_SEL_1      = 2'h0;
  localparam logic [1:0]  PRE_SEL_4      = 2'h1;
  localparam logic [3:0]  PRE_MAX_1      = 4'h0;
  localparam logic [3:0]  PRE_MAX_4      = 4'h3;
  localparam logic [3:0]  PRE_MAX_16     = 4'hf;
  localparam logic [1:0]  Q_LAST         = 2'h3;

  // units that own a trigger; the second also starts the converter
  localparam int unsigned UNIT_TRIG_MAX  = 2;
  localparam int unsigned UNIT_TRIG_ADC  = 2;

  // reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [3:0]  RST_OUTS       = 4'h0;

  typedef enum logic [1:0] {
    EPW_IDLE,
    EPW_WAIT,
    EPW_RUN
  } epw_state_t;

endpackage : epw_pkg

// File: core/epw_top.sv
// Purpose: enhanced pwm unit with compare special event trigger
// Assumes: all inputs synchronous to clk; clk is the oscillator clock
// Notes:   bridge outputs and pulses are registered
//
// Overview of operation
// R1 - trigger code pulses on compare pair match
// R2 - trigger resets selected sixteen-bit timer
// R3 - second unit also starts enabled converter
// R4 - other units treat trigger as software interrupt
// R5 - second unit's timer reset sets no flag
// R6 - config bits 7:6, mode bits 3:0
// R7 - 00 single, 10 half, 01/11 full bridge
// R8 - settings buffered, loaded at period boundary
// R9 - dead band loads at duty or period
// R10 - pwm starts only after time base reset
// R11 - period match clears timer, sets output, loads duty; code leaves the output clear when duty is zero
// R12 - period is 4 Tosc (pr+1) prescale
// R13 - no postscaler in pwm frequency
// R14 - duty is low reg with bits 5:4
// R15 - duty copied to buffer at period match
// R16 - output cleared on ten-bit duty match
// R17 - duty beyond period never clears output
// R18 - half bridge: A modulated, B complement
// R19 - half bridge delays rising edge by count
// R20 - delay beyond duty keeps output inactive
// R21 - full bridge: fwd A,D; reverse C,B
// R22 - software picks active high or low
// R23 - polarity applied last on every output
`timescale 1ns/1ps
module epw_top #(
  parameter int unsigned UNIT_NUM = 1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  unit_control_reg,
  input  wire logic [7:0]  duty_low_reg,
  input  wire logic [7:0]  pwm_period_reg,
  input  wire logic [7:0]  deadband_reg,
  input  wire logic [1:0]  prescale_sel,
  input  wire logic [15:0] compare_value_pair,
  input  wire logic [15:0] sixteen_bit_timer_a,
  input  wire logic [15:0] sixteen_bit_timer_b,
  input  wire logic        timer_b_selected,
  input  wire logic        adc_enabled,
  output logic             special_trigger,
  output logic             timer_a_reset,
  output logic             timer_b_reset,
  output logic             timer_flag_inhibit,
  output logic             adc_start,
  output logic             compare_irq,
  output logic [7:0]       pwm_time_base,
  output logic [7:0]       duty_buffer_reg,
  output logic             bridge_out_a,
  output logic             bridge_out_b,
  output logic             bridge_out_c,
  output logic             bridge_out_d
);

  // control byte fields
  logic [1:0] output_config_field;
  logic [3:0] unit_mode_field;
  logic [9:0] duty_value;
  logic       pwm_mode;

  assign output_config_field = unit_control_reg[epw_pkg::CTL_CFG_HI:epw_pkg::CTL_CFG_LO];  // [R6]
  assign unit_mode_field     = unit_control_reg[epw_pkg::CTL_MODE_HI:epw_pkg::CTL_MODE_LO]; // [R6]
  assign duty_value          = {duty_low_reg,
                                unit_control_reg[epw_pkg::CTL_DLSB_HI:epw_pkg::CTL_DLSB_LO]}; // [R14]
  assign pwm_mode            = (unit_mode_field[3:2] == epw_pkg::MODE_PWM_GRP);

  // compare and special event trigger
  logic match_prev_ff, nxt_match_prev;
  logic trig_ff, nxt_trig;
  logic rst_a_ff, nxt_rst_a;
  logic rst_b_ff, nxt_rst_b;
  logic inhib_ff, nxt_inhib;
  logic adc_ff, nxt_adc;
  logic irq_ff, nxt_irq;

  always_comb begin
    logic [15:0] sel_timer;
    logic        match;
    logic        hit;
    logic        has_trig;
    sel_timer = timer_b_selected ? sixteen_bit_timer_b : sixteen_bit_timer_a;
    match     = (unit_mode_field[3:2] == epw_pkg::MODE_CMP_GRP) && (sel_timer == compare_value_pair);
    hit       = match && !match_prev_ff;
    has_trig  = (UNIT_NUM >= 1) && (UNIT_NUM <= epw_pkg::UNIT_TRIG_MAX);
    nxt_match_prev = match;
    // trigger code raises the software interrupt compare on every unit, with or without a trigger
    nxt_irq   = hit && ((unit_mode_field == epw_pkg::MODE_CMP_SWIRQ) ||
                        (unit_mode_field == epw_pkg::MODE_CMP_TRIG)); // [R4]
    nxt_trig  = hit && has_trig && (unit_mode_field == epw_pkg::MODE_CMP_TRIG); // [R1] [R4]
    nxt_rst_a = nxt_trig && !timer_b_selected; // [R2]
    nxt_rst_b = nxt_trig && timer_b_selected;  // [R2]
    nxt_inhib = nxt_trig && (UNIT_NUM == epw_pkg::UNIT_TRIG_ADC); // [R5]
    nxt_adc   = nxt_trig && (UNIT_NUM == epw_pkg::UNIT_TRIG_ADC) && adc_enabled; // [R3]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      match_prev_ff <= 1'b0;
      trig_ff       <= 1'b0;
      rst_a_ff      <= 1'b0;
      rst_b_ff      <= 1'b0;
      inhib_ff      <= 1'b0;
      adc_ff        <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      match_prev_ff <= nxt_match_prev;
      trig_ff       <= nxt_trig;
      rst_a_ff      <= nxt_rst_a;
      rst_b_ff      <= nxt_rst_b;
      inhib_ff      <= nxt_inhib;
      adc_ff        <= nxt_adc;
      irq_ff        <= nxt_irq;
    end
  end

  assign special_trigger    = trig_ff;
  assign timer_a_reset      = rst_a_ff;
  assign timer_b_reset      = rst_b_ff;
  assign timer_flag_inhibit = inhib_ff;
  assign adc_start          = adc_ff;
  assign compare_irq        = irq_ff;

  // time base: quarter count, prescaler, timer
  logic [1:0] q_ff, nxt_q;
  logic [3:0] pre_ff, nxt_pre;
  logic [7:0] tmr_ff, nxt_tmr;
  logic       insn_tick;
  logic       tmr_tick;
  logic       period_evt;
  logic [1:0] low2;

  always_comb begin
    logic [3:0] pre_max;
    pre_max = epw_pkg::PRE_MAX_16;
    case (prescale_sel)
      epw_pkg::PRE_SEL_1: pre_max = epw_pkg::PRE_MAX_1;
      epw_pkg::PRE_SEL_4: pre_max = epw_pkg::PRE_MAX_4;
      default:            pre_max = epw_pkg::PRE_MAX_16;
    endcase
    insn_tick  = (q_ff == epw_pkg::Q_LAST);
    tmr_tick   = insn_tick && (pre_ff >= pre_max);
    // no postscaler anywhere in the period path
    period_evt = tmr_tick && (tmr_ff == pwm_period_reg); // [R12] [R13]
    nxt_q      = q_ff + 2'h1;
    nxt_pre    = pre_ff;
    nxt_tmr    = tmr_ff;
    if (insn_tick) begin
      nxt_pre = tmr_tick ? 4'h0 : pre_ff + 4'h1;
    end
    if (period_evt) begin
      nxt_tmr = 8'h00; // [R11]
    end else if (tmr_tick) begin
      nxt_tmr = tmr_ff + 8'h01;
    end
    // sub-count bits of the count this edge produces, extending the timer to ten bits
    case (prescale_sel)
      epw_pkg::PRE_SEL_1: low2 = nxt_q;
      epw_pkg::PRE_SEL_4: low2 = nxt_pre[1:0];
      default:            low2 = nxt_pre[3:2];
    endcase // [R16]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff   <= 2'h0;
      pre_ff <= 4'h0;
      tmr_ff <= epw_pkg::RST_BYTE;
    end else begin
      q_ff   <= nxt_q;
      pre_ff <= nxt_pre;
      tmr_ff <= nxt_tmr;
    end
  end

  assign pwm_time_base = tmr_ff;

  // pwm core: buffers, modulation, state
  epw_pkg::epw_state_t state_ff, nxt_state;
  logic [7:0] dbuf_ff, nxt_dbuf;
  logic [1:0] dlat_ff, nxt_dlat;
  logic [1:0] cfg_ff, nxt_cfg;
  logic [1:0] pol_ff, nxt_pol;
  logic [6:0] db_ff, nxt_db;
  logic       mod_ff, nxt_mod;
  logic       duty_match;

  always_comb begin
    // match on the coming count so the clear lands on the edge the count gets there,
    // as the set does at the period edge: high time is duty times prescale clocks
    duty_match = (state_ff == epw_pkg::EPW_RUN) &&
                 ({dbuf_ff, dlat_ff} == {nxt_tmr, low2}); // [R16] [R17]
    nxt_state  = state_ff;
    nxt_dbuf   = dbuf_ff;
    nxt_dlat   = dlat_ff;
    nxt_cfg    = cfg_ff;
    nxt_pol    = pol_ff;
    nxt_db     = db_ff;
    nxt_mod    = mod_ff;
    // duty buffer loads at every period match, any mode
    if (period_evt) begin
      nxt_dbuf = duty_value[9:2]; // [R15] [R11]
      nxt_dlat = duty_value[1:0]; // [R15]
    end
    // dead band takes whichever boundary comes first
    if (period_evt || duty_match) begin
      nxt_db = deadband_reg[epw_pkg::DB_CNT_HI:0]; // [R9]
    end
    case (state_ff)
      epw_pkg::EPW_IDLE: begin
        nxt_mod = 1'b0;
        if (pwm_mode) begin
          nxt_state = epw_pkg::EPW_WAIT;
        end
      end
      epw_pkg::EPW_WAIT: begin
        nxt_mod = 1'b0;
        if (!pwm_mode) begin
          nxt_state = epw_pkg::EPW_IDLE;
        end else if (period_evt) begin
          nxt_state = epw_pkg::EPW_RUN; // [R10]
          nxt_cfg   = output_config_field; // [R8]
          nxt_pol   = unit_mode_field[1:0]; // [R8]
          nxt_mod   = (duty_value != 10'h000); // [R11]
        end
      end
      epw_pkg::EPW_RUN: begin
        if (!pwm_mode) begin
          nxt_state = epw_pkg::EPW_IDLE;
          nxt_mod   = 1'b0;
        end else if (period_evt) begin
          nxt_cfg = output_config_field; // [R8] [R7]
          nxt_pol = unit_mode_field[1:0]; // [R8]
          nxt_mod = (duty_value != 10'h000); // [R11]
        end else if (duty_match) begin
          nxt_mod = 1'b0; // [R16]
        end
      end
      default: begin
        nxt_state = epw_pkg::EPW_IDLE;
        nxt_mod   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= epw_pkg::EPW_IDLE;
      dbuf_ff  <= epw_pkg::RST_BYTE;
      dlat_ff  <= 2'h0;
      cfg_ff   <= epw_pkg::CFG_SINGLE;
      pol_ff   <= 2'h0;
      db_ff    <= 7'h00;
      mod_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dbuf_ff  <= nxt_dbuf;
      dlat_ff  <= nxt_dlat;
      cfg_ff   <= nxt_cfg;
      pol_ff   <= nxt_pol;
      db_ff    <= nxt_db;
      mod_ff   <= nxt_mod;
    end
  end

  assign duty_buffer_reg = dbuf_ff;

  // dead band and output stage
  // index 0 follows the modulated signal, index 1 its complement
  logic [6:0] dcnt_ff  [2];
  logic [6:0] nxt_dcnt [2];
  logic [1:0] half_act;
  logic [3:0] out_ff, nxt_out;

  always_comb begin
    logic [1:0] raw;
    logic       running;
    logic [3:0] act;
    act     = 4'h0; // order d c b a
    running = (state_ff == epw_pkg::EPW_RUN);
    raw[0]  = running && mod_ff;
    raw[1]  = running && !mod_ff;
    for (int i = 0; i < 2; i++) begin
      // count instruction cycles while the raw level stays active
      if (!raw[i] || (cfg_ff != epw_pkg::CFG_HALF)) begin
        nxt_dcnt[i] = 7'h00;
      end else if (insn_tick && (dcnt_ff[i] < db_ff)) begin
        nxt_dcnt[i] = dcnt_ff[i] + 7'h01; // [R19]
      end else begin
        nxt_dcnt[i] = dcnt_ff[i];
      end
      // a delay longer than the active time never lets the edge through
      half_act[i] = raw[i] && (dcnt_ff[i] >= db_ff); // [R19] [R20]
    end
    if (running) begin
      case (cfg_ff)
        epw_pkg::CFG_SINGLE:   act = {3'h0, mod_ff}; // [R7]
        epw_pkg::CFG_HALF:     act = {2'h0, half_act[1], half_act[0]}; // [R18] [R7]
        epw_pkg::CFG_FULL_FWD: act = {mod_ff, 2'h0, 1'b1}; // [R21] [R7]
        epw_pkg::CFG_FULL_REV: act = {1'b0, 1'b1, mod_ff, 1'b0}; // [R21] [R7]
        default:               act = 4'h0;
      endcase
    end
    // polarity last: pol[1] inverts a and c, pol[0] inverts b and d
    if (state_ff == epw_pkg::EPW_IDLE) begin
      nxt_out = epw_pkg::RST_OUTS;
    end else begin
      nxt_out = act ^ {pol_ff[0], pol_ff[1], pol_ff[0], pol_ff[1]}; // [R22] [R23]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dcnt_ff[0] <= 7'h00;
      dcnt_ff[1] <= 7'h00;
      out_ff     <= epw_pkg::RST_OUTS;
    end else begin
      dcnt_ff[0] <= nxt_dcnt[0];
      dcnt_ff[1] <= nxt_dcnt[1];
      out_ff     <= nxt_out;
    end
  end

  assign bridge_out_a = out_ff[0];
  assign bridge_out_b = out_ff[1];
  assign bridge_out_c = out_ff[2];
  assign bridge_out_d = out_ff[3];

endmodule : epw_top

// File: verification/epw_asserts.sv
// Purpose: port assertions for epw_top
// Assumes: one clock, rst synchronous active high
// Notes:   bound to the design from the bench top
`timescale 1ns/1ps
module epw_asserts #(
  parameter int unsigned UNIT_NUM = 1
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  unit_control_reg,
  input wire logic [7:0]  duty_low_reg,
  input wire logic [7:0]  pwm_period_reg,
  input wire logic [7:0]  deadband_reg,
  input wire logic [1:0]  prescale_sel,
  input wire logic [15:0] compare_value_pair,
  input wire logic [15:0] sixteen_bit_timer_a,
  input wire logic [15:0] sixteen_bit_timer_b,
  input wire logic        timer_b_selected,
  input wire logic        adc_enabled,
  input wire logic        special_trigger,
  input wire logic        timer_a_reset,
  input wire logic        timer_b_reset,
  input wire logic        timer_flag_inhibit,
  input wire logic        adc_start,
  input wire logic        compare_irq,
  input wire logic [7:0]  pwm_time_base,
  input wire logic [7:0]  duty_buffer_reg,
  input wire logic        bridge_out_a,
  input wire logic        bridge_out_b,
  input wire logic        bridge_out_c,
  input wire logic        bridge_out_d
);
  logic       m;
  logic [3:0] md;
  assign m  = (timer_b_selected ? sixteen_bit_timer_b : sixteen_bit_timer_a) == compare_value_pair;
  assign md = unit_control_reg[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_trig; m && !$past(m) && md == 4'hb |=> special_trigger == (UNIT_NUM <= 2); endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse wrong");
  property p_tmr; special_trigger || timer_a_reset || timer_b_reset |-> special_trigger &&
    timer_a_reset != $past(timer_b_selected) && timer_b_reset == $past(timer_b_selected); endproperty
  a_tmr: assert property (p_tmr) else $error("timer reset wrong");
  property p_adc; special_trigger || adc_start |->
    adc_start == (special_trigger && UNIT_NUM == 2 && $past(adc_enabled)); endproperty
  a_adc: assert property (p_adc) else $error("converter start wrong");
  property p_inh; special_trigger || timer_flag_inhibit |->
    timer_flag_inhibit == (special_trigger && UNIT_NUM == 2); endproperty
  a_inh: assert property (p_inh) else $error("flag inhibit wrong");
  property p_irq; m && !$past(m) && md[3:1] == 3'h5 |=> compare_irq; endproperty
  a_irq: assert property (p_irq) else $error("compare irq missing");
  property p_once; compare_irq |=> !compare_irq; endproperty
  a_once: assert property (p_once) else $error("compare irq too long");
  property p_time; $changed(pwm_time_base) |-> pwm_time_base == $past(pwm_time_base) + 8'h01 ||
    pwm_time_base == 8'h00 && $past(pwm_time_base) == $past(pwm_period_reg); endproperty
  a_time: assert property (p_time) else $error("time base step wrong");
  property p_dbuf; $changed(duty_buffer_reg) |-> pwm_time_base == 8'h00; endproperty
  a_dbuf: assert property (p_dbuf) else $error("duty buffer off boundary");
endmodule : epw_asserts

// File: verification/epw_bridge_model.sv
// Purpose: bridge driver stand-in counting high samples
// Assumes: counts restart on the edge where clr is high
// Notes:   overlap flags a and b high together
`timescale 1ns/1ps
module epw_bridge_model (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        bridge_out_a,
  input  wire logic        bridge_out_b,
  input  wire logic        bridge_out_c,
  input  wire logic        bridge_out_d,
  output logic      [15:0] cnt_a,
  output logic      [15:0] cnt_b,
  output logic      [15:0] cnt_c,
  output logic      [15:0] cnt_d,
  output logic             overlap
);
  always_ff @(posedge clk) begin
    cnt_a   <= (clr ? 16'h0000 : cnt_a) + {15'h0000, bridge_out_a};
    cnt_b   <= (clr ? 16'h0000 : cnt_b) + {15'h0000, bridge_out_b};
    cnt_c   <= (clr ? 16'h0000 : cnt_c) + {15'h0000, bridge_out_c};
    cnt_d   <= (clr ? 16'h0000 : cnt_d) + {15'h0000, bridge_out_d};
    overlap <= (clr ? 1'b0 : overlap) | (bridge_out_a & bridge_out_b);
  end
endmodule : epw_bridge_model

// File: verification/epw_tb.sv
// Purpose: self-checking bench for epw_top
// Assumes: unit two, inputs driven on the falling edge
// Notes:   high times are counted by the bridge model
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  unit_control_reg = 8'h00;
  logic [7:0]  duty_low_reg = 8'h00;
  logic [7:0]  pwm_period_reg = 8'h00;
  logic [7:0]  deadband_reg = 8'h00;
  logic [1:0]  prescale_sel = 2'h0;
  logic [15:0] compare_value_pair = 16'h1234;
  logic [15:0] sixteen_bit_timer_a = 16'h0000;
  logic [15:0] sixteen_bit_timer_b = 16'h0000;
  logic        timer_b_selected = 1'b0;
  logic        adc_enabled = 1'b0;
  logic        special_trigger, timer_a_reset, timer_b_reset, timer_flag_inhibit, adc_start, compare_irq;
  logic        bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d, overlap;
  logic        clr = 1'b0;
  logic [7:0]  pwm_time_base, duty_buffer_reg;
  logic [15:0] cnt_a, cnt_b, cnt_c, cnt_d;
  logic [5:0]  pulses;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  assign pulses = {special_trigger, timer_a_reset, timer_b_reset, timer_flag_inhibit, adc_start, compare_irq};
  epw_top #(.UNIT_NUM(2)) u_epw_top (
    .clk                 (clk),
    .rst                 (rst),
    .unit_control_reg    (unit_control_reg),
    .duty_low_reg        (duty_low_reg),
    .pwm_period_reg      (pwm_period_reg),
    .deadband_reg        (deadband_reg),
    .prescale_sel        (prescale_sel),
    .compare_value_pair  (compare_value_pair),
    .sixteen_bit_timer_a (sixteen_bit_timer_a),
    .sixteen_bit_timer_b (sixteen_bit_timer_b),
    .timer_b_selected    (timer_b_selected),
    .adc_enabled         (adc_enabled),
    .special_trigger     (special_trigger),
    .timer_a_reset       (timer_a_reset),
    .timer_b_reset       (timer_b_reset),
    .timer_flag_inhibit  (timer_flag_inhibit),
    .adc_start           (adc_start),
    .compare_irq         (compare_irq),
    .pwm_time_base       (pwm_time_base),
    .duty_buffer_reg     (duty_buffer_reg),
    .bridge_out_a        (bridge_out_a),
    .bridge_out_b        (bridge_out_b),
    .bridge_out_c        (bridge_out_c),
    .bridge_out_d        (bridge_out_d)
  );
  epw_bridge_model u_epw_bridge_model (
    .clk          (clk),
    .clr          (clr),
    .bridge_out_a (bridge_out_a),
    .bridge_out_b (bridge_out_b),
    .bridge_out_c (bridge_out_c),
    .bridge_out_d (bridge_out_d),
    .cnt_a        (cnt_a),
    .cnt_b        (cnt_b),
    .cnt_c        (cnt_c),
    .cnt_d        (cnt_d),
    .overlap      (overlap)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic rng(input string nm, input logic [15:0] got, input int lo, input int hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("[FAIL] %s expected %0d to %0d seen %0d", nm, lo, hi, got);
    end
  endtask : rng

  task automatic quad(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] ec, input logic [7:0] ed);
    chk("count a", cnt_a, ea);
    chk("count b", cnt_b, eb);
    chk("count c", cnt_c, ec);
    chk("count d", cnt_d, ed);
  endtask : quad

  task automatic cmp_case(input logic [3:0] md, input logic sel, input logic ae, input logic [5:0] exp);
    unit_control_reg = {4'h0, md};
    timer_b_selected = sel;
    adc_enabled = ae;
    sixteen_bit_timer_a = 16'h0000;
    sixteen_bit_timer_b = 16'h0000;
    @(negedge clk);
    if (sel) begin
      sixteen_bit_timer_b = compare_value_pair;
    end else begin
      sixteen_bit_timer_a = compare_value_pair;
    end
    @(negedge clk);
    chk("pulses", pulses, exp);
    @(negedge clk);
    chk("pulses held match", pulses, 6'h00);
  endtask : cmp_case

  // period never shrinks between calls so the time base never wraps
  task automatic pwm_case(input logic [7:0] ctl, input logic [7:0] dl, input logic [7:0] pr,
                          input logic [7:0] db, input logic [1:0] ps, input int per);
    unit_control_reg = ctl;
    duty_low_reg = dl;
    pwm_period_reg = pr;
    deadband_reg = db;
    prescale_sel = ps;
    repeat (3 * per + 64) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (4 * per - 1) @(negedge clk);
  endtask : pwm_case

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    cmp_case(4'hb, 1'b0, 1'b1, 6'h37);
    cmp_case(4'hb, 1'b1, 1'b0, 6'h2d);
    cmp_case(4'ha, 1'b0, 1'b1, 6'h01);
    cmp_case(4'h8, 1'b0, 1'b1, 6'h00);
    pwm_case(8'h2c, 8'h01, 8'h01, 8'h00, 2'h0, 8);
    quad(8'h18, 8'h00, 8'h00, 8'h00);
    chk("duty buffer", duty_buffer_reg, 8'h01);
    pwm_case(8'h1c, 8'h01, 8'h01, 8'h00, 2'h1, 32);
    quad(8'h50, 8'h00, 8'h00, 8'h00);
    pwm_case(8'h2c, 8'h00, 8'h01, 8'h00, 2'h2, 128);
    quad(8'h80, 8'h00, 8'h00, 8'h00);
    pwm_case(8'h0c, 8'h03, 8'h01, 8'h00, 2'h0, 8);
    quad(8'h20, 8'h00, 8'h00, 8'h00);
    pwm_case(8'h0c, 8'h00, 8'h01, 8'h00, 2'h0, 8);
    quad(8'h00, 8'h00, 8'h00, 8'h00);
    pwm_case(8'h6c, 8'h01, 8'h03, 8'h00, 2'h0, 16);
    quad(8'h40, 8'h00, 8'h00, 8'h18);
    pwm_case(8'hec, 8'h01, 8'h03, 8'h00, 2'h0, 16);
    quad(8'h00, 8'h18, 8'h40, 8'h00);
    pwm_case(8'h2f, 8'h01, 8'h03, 8'h00, 2'h0, 16);
    quad(8'h28, 8'h40, 8'h40, 8'h40);
    pwm_case(8'h8c, 8'h04, 8'h07, 8'h00, 2'h0, 32);
    quad(8'h40, 8'h40, 8'h00, 8'h00);
    pwm_case(8'h8c, 8'h04, 8'h07, 8'h01, 2'h0, 32);
    rng("delayed a", cnt_a, 36, 48);
    rng("delayed b", cnt_b, 36, 48);
    chk("overlap", overlap, 16'h0000);
    pwm_case(8'h8c, 8'h04, 8'h07, 8'h05, 2'h0, 32);
    quad(8'h00, 8'h00, 8'h00, 8'h00);
    complete_run();
  end
endmodule : testbench

bind epw_top epw_asserts #(.UNIT_NUM(UNIT_NUM)) u_epw_asserts (.*);
